// >>> inc/sfbs_consts.vh
`ifndef SFBS_CONSTS_VH
`define SFBS_CONSTS_VH
// command codes on the local command port
`define SFBS_CMD_W            2
`define SFBS_CMD_PROG_FEAT    2'h0
`define SFBS_CMD_READ_FEAT    2'h1
`define SFBS_CMD_PROG_LOCK    2'h2
`define SFBS_CMD_READ_KEY     2'h3
// word widths
`define SFBS_FEAT_W           16
`define SFBS_LOCK_W           32
// feature word field positions
`define SFBS_F_DONE_IO        15
`define SFBS_F_INIT_IO        14
`define SFBS_F_RECFG_IO       13
`define SFBS_F_SLV_EXCL       12
`define SFBS_F_I3C_ONLY       11
`define SFBS_F_PWD_ARRAY      10
`define SFBS_F_PWD_FUSE       9
`define SFBS_F_BOOT_HI        8
`define SFBS_F_BOOT_LO        6
`define SFBS_F_CUSTOMER_IDENT_AS_DEVICE_IDENT         5
`define SFBS_F_DEC_HI         4
`define SFBS_F_DEC_LO         3
`define SFBS_F_RSVD           2
`define SFBS_F_AUTH_HI        1
`define SFBS_F_AUTH_LO        0
// feature word defaults
`define SFBS_FEAT_HW_RST      16'h0000
`define SFBS_BOOT_SW_DFLT     3'h5
// boot codes
`define SFBS_BOOT_SINGLE      3'h3
`define SFBS_BOOT_DUAL        3'h5
`define SFBS_BOOT_NONE        3'h7
// decrypt and auth codes
`define SFBS_DEC_ENC_ONLY     2'h2
`define SFBS_DEC_UNDEF        2'h1
`define SFBS_AUTH_SIG         2'h1
`define SFBS_AUTH_MAC         2'h2
// lock word field positions
`define SFBS_L_RSVD_HI        31
`define SFBS_L_RSVD_LO        28
`define SFBS_L_KEY_HLOCK      27
`define SFBS_L_KEY_RLOCK      26
`define SFBS_L_RSVD_ZERO      4'h0
`define SFBS_LOCK_HW_RST      32'h0000_0000
// nonvolatile program time in cycles
`define SFBS_PROG_CYC         8
`endif

// >>> core/sfbs_nv_word.v
`timescale 1ns/10ps
`include "sfbs_consts.vh"
// one nonvolatile word: write, busy timer, shadow copy
module sfbs_nv_word #(
    parameter WIDTH    = 16,
    parameter PROG_CYC = 8,
    parameter ONE_TIME = 0
) (
    // clock and reset
    input  wire             clk,
    input  wire             rstN,
    // program request
    input  wire             progStb,
    input  wire [WIDTH-1:0] progData,
    // state
    output reg  [WIDTH-1:0] shadow_reg,
    output wire             busy
);
    reg [7:0]       timer_reg;       // program time left
    reg [WIDTH-1:0] pend_reg;        // word being burned
    assign busy = (timer_reg != 8'h00);
    // the shadow updates only when the burn completes
    always @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            timer_reg  <= 8'h00;
            pend_reg   <= {WIDTH{1'b0}};
            shadow_reg <= {WIDTH{1'b0}};
        end
        else if (busy)
        begin
            timer_reg <= timer_reg - 8'h01;
            if (timer_reg == 8'h01)
            begin
                // fuses only ever gain bits on a one-time word
                shadow_reg <= ONE_TIME ? (shadow_reg | pend_reg) : pend_reg;
            end
        end
        else if (progStb)
        begin
            timer_reg <= PROG_CYC[7:0];
            pend_reg  <= progData;
        end
    end
endmodule

// >>> core/sfbs_pin_mux.v
`timescale 1ns/10ps
// one dedicated config pin shared with user io
module sfbs_pin_mux (
    // selection
    input  wire userSel,
    // dedicated function
    input  wire cfgOut,
    input  wire cfgOe,
    // user function
    input  wire userOut,
    input  wire userOe,
    input  wire padIn,
    // pad side
    output wire padOut,
    output wire padOe,
    output wire cfgIn,
    output wire userIn
);
    assign padOut = userSel ? userOut : cfgOut;
    assign padOe  = userSel ? userOe : cfgOe;
    // unselected config input sees idle high, unselected user input sees low, so neither misreads the pad
    assign cfgIn  = userSel ? 1'b1 : padIn;
    assign userIn = userSel ? padIn : 1'b0;
endmodule

// >>> core/sfbs_store.v
`timescale 1ns/10ps
`include "sfbs_consts.vh"
// Summary of operation
// - program command burns 16-bit feature word
// - bit 15 frees done pin to user
// - bit 14 frees init status pin
// - bit 13 frees reconfig request pin
// - bit 12 slave-only, valid with bit 13
// - bit 11 forces I3C only, I2C off
// - bit 10 extends password to array
// - bit 9 password guards fuse programming
// - bits 8:6 pick single, dual, no boot
// - customer ID enable selects reported ID
// - bits 4:3 pick decryption policy
// - bits 1:0 pick authentication method
// - readback returns feature shadow word
// - lock command burns 32-bit lock word
// - bit 27 hard-locks signing key fuses
// - bit 26 blocks signing key readout
// - soft lock blocks external ports only
// - hard lock blocks every interface
module sfbs_store #(
    parameter PROG_CYC = `SFBS_PROG_CYC,
    parameter [31:0] HW_DEVICE_ID = 32'h0000_1234  // arbitrary value
) (
    // clock and reset
    clk,
    rst_n,
    // command port
    cmdValid,
    cmdCode,
    cmdFromFabric,
    cmdData,
    cmdPassOk,
    cmdReady,
    cmdDone,
    cmdRefused,
    rdData,
    // key fuse readback source
    keyFuseWord,
    // customer id from the user feature store
    customerId,
    // decoded feature outputs
    doneUserIo,
    initUserIo,
    reconfigUserIo,
    slaveOnly,
    i3cOnly,
    pwdArray,
    pwdFuse,
    bootSingle,
    bootDual,
    bootNone,
    bootInvalid,
    encOnly,
    decUndefined,
    authSig,
    authMac,
    deviceId,
    keyHardLocked,
    keyReadLocked,
    // shared pins
    initCfgOut,
    initCfgOe,
    initUserOut,
    initUserOe,
    initPadIn,
    initPadOut,
    initPadOe,
    initCfgIn,
    initUserIn,
    rcfgUserOut,
    rcfgUserOe,
    rcfgPadIn,
    rcfgPadOut,
    rcfgPadOe,
    rcfgCfgIn,
    rcfgUserIn
);
    // clock and reset
    input  wire        clk;
    input  wire        rst_n;
    // command port
    input  wire        cmdValid;
    input  wire [1:0]  cmdCode;
    input  wire        cmdFromFabric;
    input  wire [31:0] cmdData;
    input  wire        cmdPassOk;
    output wire        cmdReady;
    output reg         cmdDone;
    output reg         cmdRefused;
    output reg  [31:0] rdData;
    // key fuse readback source
    input  wire [31:0] keyFuseWord;
    // customer id
    input  wire [31:0] customerId;
    // decoded feature outputs
    output wire        doneUserIo;
    output wire        initUserIo;
    output wire        reconfigUserIo;
    output wire        slaveOnly;
    output wire        i3cOnly;
    output wire        pwdArray;
    output wire        pwdFuse;
    output wire        bootSingle;
    output wire        bootDual;
    output wire        bootNone;
    output wire        bootInvalid;
    output wire        encOnly;
    output wire        decUndefined;
    output wire        authSig;
    output wire        authMac;
    output reg  [31:0] deviceId;
    output wire        keyHardLocked;
    output wire        keyReadLocked;
    // shared pins
    input  wire        initCfgOut;
    input  wire        initCfgOe;
    input  wire        initUserOut;
    input  wire        initUserOe;
    input  wire        initPadIn;
    output wire        initPadOut;
    output wire        initPadOe;
    output wire        initCfgIn;
    output wire        initUserIn;
    input  wire        rcfgUserOut;
    input  wire        rcfgUserOe;
    input  wire        rcfgPadIn;
    output wire        rcfgPadOut;
    output wire        rcfgPadOe;
    output wire        rcfgCfgIn;
    output wire        rcfgUserIn;

    reg         rstSync1_reg;        // reset release stage one
    reg         rstSync2_reg;        // synchronised reset
    wire        rstN;                // reset used by all logic
    wire [15:0] featWord;            // feature shadow
    wire [31:0] lockWord;            // lock shadow
    wire        featBusy;            // feature burn in progress
    wire        lockBusy;            // lock burn in progress
    wire        featStb;             // accepted feature program
    wire        lockStb;             // accepted lock program
    wire [2:0]  bootSel;             // boot field
    wire [1:0]  decSel;              // decrypt field
    wire [1:0]  authSel;             // auth field
    reg         accept;              // request allowed
    reg         opBusy_reg;          // waiting for a burn to finish

    // async assert, synchronous release
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstSync1_reg <= 1'b0;
            rstSync2_reg <= 1'b0;
        end
        else
        begin
            rstSync1_reg <= 1'b1;
            rstSync2_reg <= rstSync1_reg;
        end
    end
    assign rstN = rstSync2_reg;

    // one request at a time; stall while a burn is running
    assign cmdReady = !opBusy_reg && !featBusy && !lockBusy;

    // access policy per command
    always @*
    begin
        accept = 1'b1;
        case (cmdCode)
            `SFBS_CMD_PROG_FEAT: accept = !pwdFuse || cmdPassOk;
            `SFBS_CMD_PROG_LOCK: accept = !pwdFuse || cmdPassOk;
            // readout lock stops external ports, hard lock stops all
            `SFBS_CMD_READ_KEY:  accept = !keyHardLocked && !(keyReadLocked && !cmdFromFabric);
            `SFBS_CMD_READ_FEAT: accept = 1'b1;
            default:             accept = 1'b0;
        endcase
    end

    // a refused program never reaches either fuse word
    assign featStb = cmdValid && cmdReady && accept && (cmdCode == `SFBS_CMD_PROG_FEAT);
    assign lockStb = cmdValid && cmdReady && accept && (cmdCode == `SFBS_CMD_PROG_LOCK);

    // feature word store, reserved bit forced to zero
    sfbs_nv_word #(
        .WIDTH    (`SFBS_FEAT_W),
        .PROG_CYC (PROG_CYC),
        .ONE_TIME (0)
    ) uFeat (
        .clk        (clk),
        .rstN       (rstN),
        .progStb    (featStb),
        .progData   (cmdData[15:0] & ~(16'h0001 << `SFBS_F_RSVD)),
        .shadow_reg (featWord),
        .busy       (featBusy)
    );

    // lock word takes bits 27:0 only; reserved top nibble forced to zero
    sfbs_nv_word #(
        .WIDTH    (`SFBS_LOCK_W),
        .PROG_CYC (PROG_CYC),
        .ONE_TIME (1)
    ) uLock (
        .clk        (clk),
        .rstN       (rstN),
        .progStb    (lockStb),
        .progData   ({`SFBS_L_RSVD_ZERO, cmdData[27:0]}),
        .shadow_reg (lockWord),
        .busy       (lockBusy)
    );

    // command completion and readback data
    always @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            cmdDone    <= 1'b0;
            cmdRefused <= 1'b0;
            rdData     <= 32'h0000_0000;
            opBusy_reg <= 1'b0;
        end
        else
        begin
            cmdDone    <= 1'b0;
            cmdRefused <= 1'b0;
            if (opBusy_reg)
            begin
                // burn finished: report completion
                if (!featBusy && !lockBusy)
                begin
                    opBusy_reg <= 1'b0;
                    cmdDone    <= 1'b1;
                end
            end
            else if (cmdValid && cmdReady)
            begin
                if (!accept)
                begin
                    cmdRefused <= 1'b1;
                    cmdDone    <= 1'b1;
                    rdData     <= 32'h0000_0000;
                end
                else if (featStb || lockStb)
                begin
                    opBusy_reg <= 1'b1;
                end
                else if (cmdCode == `SFBS_CMD_READ_FEAT)
                begin
                    rdData  <= {16'h0000, featWord};
                    cmdDone <= 1'b1;
                end
                else
                begin
                    rdData  <= keyFuseWord;
                    cmdDone <= 1'b1;
                end
            end
        end
    end

    // decoded features
    assign doneUserIo     = featWord[`SFBS_F_DONE_IO];
    assign initUserIo     = featWord[`SFBS_F_INIT_IO];
    assign reconfigUserIo = featWord[`SFBS_F_RECFG_IO];
    // slave-only has no meaning unless the request pin is freed
    assign slaveOnly      = featWord[`SFBS_F_SLV_EXCL] && reconfigUserIo;
    assign i3cOnly        = featWord[`SFBS_F_I3C_ONLY];
    assign pwdArray       = featWord[`SFBS_F_PWD_ARRAY];
    assign pwdFuse        = featWord[`SFBS_F_PWD_FUSE];
    assign bootSel        = featWord[`SFBS_F_BOOT_HI:`SFBS_F_BOOT_LO];
    assign bootSingle     = (bootSel == `SFBS_BOOT_SINGLE);
    assign bootDual       = (bootSel == `SFBS_BOOT_DUAL);
    assign bootNone       = (bootSel == `SFBS_BOOT_NONE);
    assign bootInvalid    = !(bootSingle || bootDual || bootNone);
    assign decSel         = featWord[`SFBS_F_DEC_HI:`SFBS_F_DEC_LO];
    assign encOnly        = (decSel == `SFBS_DEC_ENC_ONLY);
    assign decUndefined   = (decSel == `SFBS_DEC_UNDEF);
    assign authSel        = featWord[`SFBS_F_AUTH_HI:`SFBS_F_AUTH_LO];
    assign authSig        = (authSel == `SFBS_AUTH_SIG);
    assign authMac        = (authSel == `SFBS_AUTH_MAC);
    assign keyHardLocked  = lockWord[`SFBS_L_KEY_HLOCK];
    assign keyReadLocked  = lockWord[`SFBS_L_KEY_RLOCK];

    // reported device id, registered
    always @(posedge clk or negedge rstN)
    begin
        if (!rstN)
            deviceId <= 32'h0000_0000;
        else
            deviceId <= featWord[`SFBS_F_CUSTOMER_IDENT_AS_DEVICE_IDENT] ? customerId : HW_DEVICE_ID;
    end

    // init status pin sharing
    sfbs_pin_mux uInitPin (
        .userSel (initUserIo),
        .cfgOut  (initCfgOut),
        .cfgOe   (initCfgOe),
        .userOut (initUserOut),
        .userOe  (initUserOe),
        .padIn   (initPadIn),
        .padOut  (initPadOut),
        .padOe   (initPadOe),
        .cfgIn   (initCfgIn),
        .userIn  (initUserIn)
    );

    // reconfig request pin is input only in its dedicated role
    sfbs_pin_mux uRcfgPin (
        .userSel (reconfigUserIo),
        .cfgOut  (1'b0),
        .cfgOe   (1'b0),
        .userOut (rcfgUserOut),
        .userOe  (rcfgUserOe),
        .padIn   (rcfgPadIn),
        .padOut  (rcfgPadOut),
        .padOe   (rcfgPadOe),
        .cfgIn   (rcfgCfgIn),
        .userIn  (rcfgUserIn)
    );
endmodule

// >>> test/sfbs_store_checker.sv
`timescale 1ns/10ps
`include "sfbs_consts.vh"
// protocol and decode watcher on the store's ports
module sfbs_store_checker #(
    parameter PROG_CYC = 8
) (
    // clock and reset
    input wire        clk,
    input wire        rst_n,
    // command port
    input wire        cmdValid,
    input wire [1:0]  cmdCode,
    input wire        cmdFromFabric,
    input wire        cmdPassOk,
    input wire        cmdReady,
    input wire        cmdDone,
    input wire        cmdRefused,
    input wire [31:0] rdData,
    input wire [31:0] keyFuseWord,
    // decoded levels
    input wire        doneUserIo,
    input wire        initUserIo,
    input wire        reconfigUserIo,
    input wire        slaveOnly,
    input wire        i3cOnly,
    input wire        pwdArray,
    input wire        pwdFuse,
    input wire        bootSingle,
    input wire        bootDual,
    input wire        bootNone,
    input wire        bootInvalid,
    input wire        encOnly,
    input wire        decUndefined,
    input wire        authSig,
    input wire        authMac,
    input wire        keyHardLocked,
    input wire        keyReadLocked
);
    // burn answer lands one cycle after the shadow update
    localparam int DL = PROG_CYC + 1;
    // taken requests by kind; both burn codes have bit 0 clear
    wire rdTk = cmdValid && cmdReady && cmdCode == `SFBS_CMD_READ_FEAT;
    wire prTk = cmdValid && cmdReady && !cmdCode[0];
    wire kyTk = cmdValid && cmdReady && cmdCode == `SFBS_CMD_READ_KEY;
    wire noPw = pwdFuse && !cmdPassOk;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    a_read_answer:
    assert property (rdTk |=> cmdDone && !cmdRefused && rdData[31:16] == 16'h0000 && !rdData[2])
        else $error("feature readback answer wrong");
    a_pin_bits:
    assert property (rdTk |=> {doneUserIo, initUserIo, reconfigUserIo, slaveOnly} ==
        {rdData[15:13], rdData[12] & rdData[13]}) else $error("pin release levels wrong");
    a_port_pwd:
    assert property (rdTk |=> {i3cOnly, pwdArray, pwdFuse} == rdData[11:9])
        else $error("port or password levels wrong");
    a_boot_decode:
    assert property (rdTk |=> bootSingle == (rdData[8:6] == 3'h3) && bootDual == (rdData[8:6] ==
        3'h5) && bootNone == (rdData[8:6] == 3'h7) && bootInvalid == (rdData[8:6] != 3'h3 &&
        rdData[8:6] != 3'h5 && rdData[8:6] != 3'h7)) else $error("boot decode wrong");
    a_dec_auth:
    assert property (rdTk |=> encOnly == (rdData[4:3] == 2'h2) && decUndefined == (rdData[4:3]
        == 2'h1) && authSig == (rdData[1:0] == 2'h1) && authMac == (rdData[1:0] == 2'h2))
        else $error("decrypt or auth decode wrong");
    a_prog_timing:
    assert property (prTk && !noPw |=> !cmdReady ##DL cmdDone && !cmdRefused)
        else $error("burn timing wrong");
    a_pwd_refuse:
    assert property (prTk && noPw |=> cmdDone && cmdRefused)
        else $error("unguarded burn not refused");
    a_key_refuse:
    assert property (kyTk && (keyHardLocked || keyReadLocked && !cmdFromFabric)
        |=> cmdDone && cmdRefused && rdData == 32'h0000_0000) else $error("key read not refused");
    a_fabric_read:
    assert property (kyTk && !keyHardLocked && (cmdFromFabric || !keyReadLocked)
        |=> !cmdRefused && rdData == $past(keyFuseWord)) else $error("key read wrongly blocked");
    a_lock_sticky:
    assert property (!$fell(keyHardLocked) && !$fell(keyReadLocked))
        else $error("lock bit cleared");
endmodule

bind sfbs_store sfbs_store_checker #(.PROG_CYC(PROG_CYC)) u_chk (
    .clk(clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdFromFabric(cmdFromFabric), .cmdPassOk(cmdPassOk), .cmdReady(cmdReady),
    .cmdDone(cmdDone), .cmdRefused(cmdRefused), .rdData(rdData), .keyFuseWord(keyFuseWord),
    .doneUserIo(doneUserIo), .initUserIo(initUserIo), .reconfigUserIo(reconfigUserIo),
    .slaveOnly(slaveOnly), .i3cOnly(i3cOnly), .pwdArray(pwdArray), .pwdFuse(pwdFuse),
    .bootSingle(bootSingle), .bootDual(bootDual), .bootNone(bootNone),
    .bootInvalid(bootInvalid), .encOnly(encOnly), .decUndefined(decUndefined),
    .authSig(authSig), .authMac(authMac), .keyHardLocked(keyHardLocked),
    .keyReadLocked(keyReadLocked)
);

// >>> test/sfbs_host_model.sv
`timescale 1ns/10ps
`include "sfbs_consts.vh"
// configuration host: one command at a time on the command port
module sfbs_host_model (
    // clock
    input  wire         clk,
    // request side
    output logic        cmdValid,
    output logic [1:0]  cmdCode,
    output logic        cmdFromFabric,
    output logic [31:0] cmdData,
    output logic        cmdPassOk,
    // answer side
    input  wire         cmdReady,
    input  wire         cmdDone,
    input  wire         cmdRefused,
    input  wire  [31:0] rdData
);
    // idle request at time zero
    initial
    begin
        cmdValid = 1'b0;
        cmdCode = 2'h1;
        cmdFromFabric = 1'b0;
        cmdData = 32'h0000_0000;
        cmdPassOk = 1'b0;
    end
    // request held until the taking edge; answer read mid-cycle
    task automatic issue(input logic [1:0] c, input logic [31:0] d, input logic fab,
        input logic pok, output logic ok, output logic rf, output logic [31:0] rd);
        int n;
        begin
            n = 0;
            @(posedge clk);
            cmdCode <= c;
            // lock word: top nibble always zero
            cmdData <= (c == `SFBS_CMD_PROG_LOCK) ? {`SFBS_L_RSVD_ZERO, d[27:0]} : d;
            cmdFromFabric <= fab;
            cmdPassOk <= pok;
            cmdValid <= 1'b1;
            @(negedge clk);
            // bounded wait for ready
            while (!cmdReady && n < 40)
            begin
                @(negedge clk);
                n++;
            end
            @(posedge clk);
            cmdValid <= 1'b0;
            // released data must not look like a held value
            cmdData <= ~cmdData;
            @(negedge clk);
            while (!cmdDone && n < 80)
            begin
                @(negedge clk);
                n++;
            end
            ok = cmdDone;
            rf = cmdRefused;
            rd = rdData;
        end
    endtask
endmodule

// >>> test/sfbs_store_tb_top.sv
`timescale 1ns/10ps
`include "sfbs_consts.vh"
// command sequences against the feature and lock store
module sfbs_store_tb_top;
    localparam [31:0] HW_ID = 32'h0000_5A5A; // arbitrary value
    localparam [31:0] CUST  = 32'h1357_9BDF;
    localparam [31:0] KEY   = 32'hC3A5_0F1E;
    // clock, reset, command wires
    logic        clk;
    logic        rst_n;
    wire         cV, cF, cP, cR, cD, cX;
    wire  [1:0]  cC;
    wire  [31:0] cW, rdW, devId;
    // decoded levels, lock levels, pin side
    wire  [14:0] dec;
    wire  [1:0]  lk;
    logic [7:0]  pinIn;
    wire  [7:0]  pinOut;
    // answer of the last command and counters
    logic        rf;
    logic [31:0] rd;
    int          errors;
    int          totalChecks;
    logic [15:0] words [5] = '{16'hFFFF, 16'h50F1, 16'h294A, 16'h8500, 16'h0380};

    sfbs_store #(.PROG_CYC(8), .HW_DEVICE_ID(HW_ID)) i_sfbs_store (
        .clk(clk), .rst_n(rst_n), .cmdValid(cV), .cmdCode(cC), .cmdFromFabric(cF),
        .cmdData(cW), .cmdPassOk(cP), .cmdReady(cR), .cmdDone(cD), .cmdRefused(cX),
        .rdData(rdW), .keyFuseWord(KEY), .customerId(CUST), .doneUserIo(dec[14]),
        .initUserIo(dec[13]), .reconfigUserIo(dec[12]), .slaveOnly(dec[11]), .i3cOnly(dec[10]),
        .pwdArray(dec[9]), .pwdFuse(dec[8]), .bootSingle(dec[7]), .bootDual(dec[6]),
        .bootNone(dec[5]), .bootInvalid(dec[4]), .encOnly(dec[3]), .decUndefined(dec[2]),
        .authSig(dec[1]), .authMac(dec[0]), .deviceId(devId), .keyHardLocked(lk[1]),
        .keyReadLocked(lk[0]), .initCfgOut(pinIn[0]), .initCfgOe(pinIn[1]),
        .initUserOut(pinIn[2]), .initUserOe(pinIn[3]), .initPadIn(pinIn[4]),
        .initPadOut(pinOut[0]), .initPadOe(pinOut[1]), .initCfgIn(pinOut[2]),
        .initUserIn(pinOut[3]), .rcfgUserOut(pinIn[5]), .rcfgUserOe(pinIn[6]),
        .rcfgPadIn(pinIn[7]), .rcfgPadOut(pinOut[4]), .rcfgPadOe(pinOut[5]),
        .rcfgCfgIn(pinOut[6]), .rcfgUserIn(pinOut[7])
    );
    sfbs_host_model i_sfbs_host_model (
        .clk(clk), .cmdValid(cV), .cmdCode(cC), .cmdFromFabric(cF), .cmdData(cW),
        .cmdPassOk(cP), .cmdReady(cR), .cmdDone(cD), .cmdRefused(cX), .rdData(rdW)
    );
    // 25 MHz clock
    always #20 clk = ~clk;
    // verdict and end of run
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", totalChecks, errors);
        if (errors == 0 && totalChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one counted comparison
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        totalChecks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one command; a lost handshake ends the run
    task automatic cmd(input logic [1:0] c, input logic [31:0] d, input logic fab, input logic pok);
        logic ok;
        begin
            i_sfbs_host_model.issue(c, d, fab, pok, ok, rf, rd);
            check("handshake", 32'h1, {31'h0, ok});
            if (ok !== 1'b1)
                tally_and_finish();
        end
    endtask
    // expected decoded levels of a feature word
    function automatic logic [14:0] expDec(input logic [15:0] w);
        logic [2:0] b;
        begin
            b = w[8:6];
            expDec = {w[15:13], w[12] & w[13], w[11:9], b == 3'h3, b == 3'h5, b == 3'h7,
                b != 3'h3 && b != 3'h5 && b != 3'h7, w[4:3] == 2'h2, w[4:3] == 2'h1,
                w[1:0] == 2'h1, w[1:0] == 2'h2};
        end
    endfunction
    // read back and compare every visible effect of the word
    task automatic readChk(input logic [15:0] e);
        cmd(`SFBS_CMD_READ_FEAT, 32'h0000_0000, 1'b0, 1'b1);
        check("feature word", {16'h0000, e}, rd);
        check("decoded", {17'h0, expDec(e)}, {17'h0, dec});
        check("device id", e[5] ? CUST : HW_ID, devId);
        check("init pin", {28'h0, e[14] & pinIn[4], e[14] | pinIn[4],
            e[14] ? pinIn[3] : pinIn[1], e[14] ? pinIn[2] : pinIn[0]}, {28'h0, pinOut[3:0]});
        check("rcfg pin", {28'h0, e[13] & pinIn[7], e[13] | pinIn[7], e[13] & pinIn[6],
            e[13] & pinIn[5]}, {28'h0, pinOut[7:4]});
    endtask
    // burn then read back; bit 2 must come back clear
    task automatic progRead(input logic [15:0] w);
        @(posedge clk);
        pinIn <= pinIn + 8'h35;
        cmd(`SFBS_CMD_PROG_FEAT, {16'h0000, w}, 1'b0, 1'b1);
        check("burn refused", 32'h0, {31'h0, rf});
        readChk(w & 16'hFFFB);
    endtask
    // key read from one source
    task automatic keyRd(input logic fab, input logic refd);
        cmd(`SFBS_CMD_READ_KEY, 32'h0000_0000, fab, 1'b1);
        check("key refused", {31'h0, refd}, {31'h0, rf});
        check("key data", refd ? 32'h0000_0000 : KEY, rd);
    endtask
    // reset held two cycles, first request after the sync copy lets go
    task automatic doReset;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    initial
    begin
        errors = 0;
        totalChecks = 0;
        clk = 1'b0;
        rst_n = 1'b0;
        pinIn = 8'h00;
        doReset();
        readChk(16'h0000);
        $display("test reset_values done");
        foreach (words[i])
            progRead(words[i]);
        $display("test feature_table done");
        // password guard on, burn without password must fail
        cmd(`SFBS_CMD_PROG_FEAT, 32'h0000_FFFF, 1'b0, 1'b0);
        check("burn refused", 32'h1, {31'h0, rf});
        readChk(16'h0380);
        progRead(16'h0000);
        $display("test password_guard done");
        keyRd(1'b0, 1'b0);
        cmd(`SFBS_CMD_PROG_LOCK, 32'hF400_0000, 1'b0, 1'b1);
        check("locks", 32'h1, {30'h0, lk});
        keyRd(1'b0, 1'b1);
        keyRd(1'b1, 1'b0);
        cmd(`SFBS_CMD_PROG_LOCK, 32'h0800_0000, 1'b0, 1'b1);
        cmd(`SFBS_CMD_PROG_LOCK, 32'h0000_0000, 1'b0, 1'b1);
        check("locks", 32'h3, {30'h0, lk});
        keyRd(1'b1, 1'b1);
        $display("test lock_word done");
        @(posedge clk);
        doReset();
        readChk(16'h0000);
        $display("test second_reset done");
        tally_and_finish();
    end
endmodule
